// file: verilog/ptc_pkg.sv
// ptc_pkg: register map, command bits, field layout and timing constants
// for the precision time clock with rate trim.
// assumes a 200 MHz pclk and a 10 ns reference step derived from it.
package ptc_pkg;

   // register byte addresses on the apb slave
   localparam logic [11:0] ADDR_CMD = 12'h104;
   localparam logic [11:0] ADDR_SEC = 12'h110;
   localparam logic [11:0] ADDR_NS = 12'h114;
   localparam logic [11:0] ADDR_FRAC = 12'h118;
   localparam logic [11:0] ADDR_RATE = 12'h11c;
   localparam logic [11:0] ADDR_TEMP = 12'h120;
   localparam logic [11:0] ADDR_DUR = 12'h124;

   // field positions
   localparam int unsigned CMD_SNAP_BIT = 0;
   localparam int unsigned CMD_LOAD_BIT = 1;
   localparam int unsigned CMD_TEMP_BIT = 2;
   localparam int unsigned STAT_TEMP_BIT = 3;
   localparam int unsigned DIR_BIT = 31;
   localparam int unsigned NS_W = 30;
   localparam int unsigned TRIM_W = 30;

   // values after reset
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [29:0] RST_NS = 30'h0000_0000;
   localparam logic [29:0] RST_TRIM = 30'h0000_0000;

   // timing
   localparam int unsigned REF_PERIOD_NS = 10;
   localparam int unsigned PCLK_MHZ = 200;
   localparam int unsigned TICK_CYCLES = (REF_PERIOD_NS * PCLK_MHZ) / 1000;

   // nanosecond steps and rollover
   localparam logic [4:0] STEP_NOM = 5'h0a;
   localparam logic [4:0] STEP_SLOW = 5'h09;
   localparam logic [4:0] STEP_FAST = 5'h0b;
   localparam logic [29:0] NS_PER_SEC = 30'h3b9a_ca00;

endpackage

// file: verilog/ptc_tick_div.sv
// ptc_tick_div: divides pclk down to a one-cycle reference tick.
// assumes div is at least 1; div of 1 gives a tick every cycle.
`timescale 1ns/1ps
module ptc_tick_div #(
   parameter int unsigned DIV = ptc_pkg::TICK_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);

   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= '0;
      end
      else if (cnt_q == LAST)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   // registered so the tick is glitch free
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick <= 1'b0;
      end
      else
      begin
         tick <= (cnt_q == LAST);
      end
   end

endmodule // ptc_tick_div

// file: verilog/ptc_time_clock.sv
// ptc_time_clock: seconds / nanoseconds / fraction time counter with
// permanent and temporary rate trim, snapshot and load, apb register slave.
// assumes an apb master on pclk; pready is always high (no wait states).
//
// How it works
// - reads of the three time registers return the copy taken when snapshot was commanded.
// - a load command copies the three time registers into the running time.
// - seconds is a full 32-bit read/write field that resets to zero.
// - nanoseconds is 30 bits wide in the low bits, resets to zero, upper two bits read zero.
// - the fraction is a 32-bit read/write field that resets to zero.
// - with no carry the nanoseconds advance by 10 on every 10 ns reference tick.
// - permanent direction 0 makes the trimmed step 9 ns, 1 makes it 11 ns.
// - every reference tick with no temporary trim running, the 30-bit permanent trim value is added to the fraction.
// - when the fraction carries out, that tick's step moves 1 ns in the chosen direction.
// - temporary direction 0 gives a 9 ns trimmed step, 1 gives 11 ns, while it is active.
// - while a temporary trim runs, its 30-bit value is added to the fraction each tick.
// - a fraction carry during a temporary trim makes the step 9 or 11 instead of 10.
// - a temporary trim lasts a programmed 32-bit number of reference ticks.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module ptc_time_clock #(
   parameter int unsigned TICK_DIV = ptc_pkg::TICK_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] time_seconds_now,
   output logic [29:0] time_nanoseconds_now,
   output logic temporary_trim_active
);

   logic tick;
   logic hit;
   logic [31:0] rd_d;
   logic [31:0] prdata_q;
   logic wr_en;
   logic rd_setup;
   logic wr_cmd, wr_sec, wr_ns, wr_frac, wr_rate, wr_temp, wr_dur;
   logic snap_cmd, load_cmd, temp_go;

   // software-side copies of the time
   logic [31:0] sec_shadow_q;
   logic [29:0] ns_shadow_q;
   logic [31:0] frac_shadow_q;

   // running time
   logic [31:0] sec_live_q;
   logic [29:0] ns_live_q;
   logic [31:0] frac_live_q;

   // trim settings
   logic rate_trim_direction_q;
   logic [29:0] rate_trim_value_q;
   logic temporary_trim_direction_q;
   logic [29:0] temporary_trim_value_q;
   logic [31:0] duration_q;
   logic [31:0] temp_cnt_q;

   // step arithmetic
   logic temp_active;
   logic eff_dir;
   logic [29:0] eff_val;
   logic [32:0] frac_sum;
   logic carry;
   logic [4:0] step;
   logic [30:0] ns_sum;
   logic ns_wrap;
   logic [30:0] ns_wrapped;

   ptc_tick_div #(
      .DIV(TICK_DIV)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   // apb decode
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;

   always_comb
   begin
      hit = 1'b1;
      rd_d = ptc_pkg::RST_WORD;
      if (paddr == ptc_pkg::ADDR_CMD)
      begin
         rd_d[ptc_pkg::STAT_TEMP_BIT] = temp_active;
      end
      else if (paddr == ptc_pkg::ADDR_SEC)
      begin
         rd_d = sec_shadow_q;
      end
      else if (paddr == ptc_pkg::ADDR_NS)
      begin
         rd_d = {2'h0, ns_shadow_q};
      end
      else if (paddr == ptc_pkg::ADDR_FRAC)
      begin
         rd_d = frac_shadow_q;
      end
      else if (paddr == ptc_pkg::ADDR_RATE)
      begin
         rd_d = {rate_trim_direction_q, 1'b0, rate_trim_value_q};
      end
      else if (paddr == ptc_pkg::ADDR_TEMP)
      begin
         rd_d = {temporary_trim_direction_q, 1'b0, temporary_trim_value_q};
      end
      else if (paddr == ptc_pkg::ADDR_DUR)
      begin
         rd_d = duration_q;
      end
      else
      begin
         hit = 1'b0;
      end
   end

   assign wr_cmd = wr_en & (paddr == ptc_pkg::ADDR_CMD);
   assign wr_sec = wr_en & (paddr == ptc_pkg::ADDR_SEC);
   assign wr_ns = wr_en & (paddr == ptc_pkg::ADDR_NS);
   assign wr_frac = wr_en & (paddr == ptc_pkg::ADDR_FRAC);
   assign wr_rate = wr_en & (paddr == ptc_pkg::ADDR_RATE);
   assign wr_temp = wr_en & (paddr == ptc_pkg::ADDR_TEMP);
   assign wr_dur = wr_en & (paddr == ptc_pkg::ADDR_DUR);

   // command bits are self clearing: they exist only as the write pulse
   assign snap_cmd = wr_cmd & pwdata[ptc_pkg::CMD_SNAP_BIT];
   assign load_cmd = wr_cmd & pwdata[ptc_pkg::CMD_LOAD_BIT];
   assign temp_go = wr_cmd & pwdata[ptc_pkg::CMD_TEMP_BIT];

   // read data is prepared in the setup phase so pready can stay high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= ptc_pkg::RST_WORD;
      end
      else if (rd_setup)
      begin
         prdata_q <= rd_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // shadow time registers: written by software or by a snapshot
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sec_shadow_q <= ptc_pkg::RST_WORD;
         ns_shadow_q <= ptc_pkg::RST_NS;
         frac_shadow_q <= ptc_pkg::RST_WORD;
      end
      else if (snap_cmd)
      begin
         sec_shadow_q <= sec_live_q;
         ns_shadow_q <= ns_live_q;
         frac_shadow_q <= frac_live_q;
      end
      else
      begin
         if (wr_sec)
         begin
            sec_shadow_q <= pwdata;
         end
         if (wr_ns)
         begin
            ns_shadow_q <= pwdata[ptc_pkg::NS_W-1:0];
         end
         if (wr_frac)
         begin
            frac_shadow_q <= pwdata;
         end
      end
   end

   // trim settings
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rate_trim_direction_q <= 1'b0;
         rate_trim_value_q <= ptc_pkg::RST_TRIM;
         temporary_trim_direction_q <= 1'b0;
         temporary_trim_value_q <= ptc_pkg::RST_TRIM;
         duration_q <= ptc_pkg::RST_WORD;
      end
      else
      begin
         if (wr_rate)
         begin
            rate_trim_direction_q <= pwdata[ptc_pkg::DIR_BIT];
            rate_trim_value_q <= pwdata[ptc_pkg::TRIM_W-1:0];
         end
         if (wr_temp)
         begin
            temporary_trim_direction_q <= pwdata[ptc_pkg::DIR_BIT];
            temporary_trim_value_q <= pwdata[ptc_pkg::TRIM_W-1:0];
         end
         if (wr_dur)
         begin
            duration_q <= pwdata;
         end
      end
   end

   // temporary trim duration, counted in reference ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         temp_cnt_q <= ptc_pkg::RST_WORD;
      end
      else if (temp_go)
      begin
         temp_cnt_q <= duration_q;
      end
      else if (tick && temp_active)
      begin
         temp_cnt_q <= temp_cnt_q - 32'h1;
      end
   end

   assign temp_active = (temp_cnt_q != ptc_pkg::RST_WORD);
   assign temporary_trim_active = temp_active;

   // pick the trim in force for this tick
   assign eff_dir = temp_active ? temporary_trim_direction_q : rate_trim_direction_q;
   assign eff_val = temp_active ? temporary_trim_value_q : rate_trim_value_q;

   assign frac_sum = {1'b0, frac_live_q} + {3'h0, eff_val};
   assign carry = frac_sum[32];

   always_comb
   begin
      step = ptc_pkg::STEP_NOM;
      if (carry)
      begin
         // same encoding for both sources, eff_dir already chose which
         step = eff_dir ? ptc_pkg::STEP_FAST : ptc_pkg::STEP_SLOW;
      end
   end

   assign ns_sum = {1'b0, ns_live_q} + {26'h0, step};
   assign ns_wrap = (ns_sum >= {1'b0, ptc_pkg::NS_PER_SEC});
   assign ns_wrapped = ns_sum - {1'b0, ptc_pkg::NS_PER_SEC};

   // running time; a load wins over the tick of the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sec_live_q <= ptc_pkg::RST_WORD;
         ns_live_q <= ptc_pkg::RST_NS;
         frac_live_q <= ptc_pkg::RST_WORD;
      end
      else if (load_cmd)
      begin
         sec_live_q <= sec_shadow_q;
         ns_live_q <= ns_shadow_q;
         frac_live_q <= frac_shadow_q;
      end
      else if (tick)
      begin
         frac_live_q <= frac_sum[31:0];
         if (ns_wrap)
         begin
            ns_live_q <= ns_wrapped[29:0];
            sec_live_q <= sec_live_q + 32'h1;
         end
         else
         begin
            ns_live_q <= ns_sum[29:0];
         end
      end
   end

   assign time_seconds_now = sec_live_q;
   assign time_nanoseconds_now = ns_live_q;

   chk_snap_copies: assert property (
      @(posedge pclk) disable iff (!presetn)
      snap_cmd |=> (sec_shadow_q == $past(sec_live_q)) && (ns_shadow_q == $past(ns_live_q))
         && (frac_shadow_q == $past(frac_live_q)))
      else $error("snapshot did not copy running time");

   chk_load_replaces: assert property (
      @(posedge pclk) disable iff (!presetn)
      load_cmd |=> (sec_live_q == $past(sec_shadow_q)) && (ns_live_q == $past(ns_shadow_q))
         && (frac_live_q == $past(frac_shadow_q)))
      else $error("load did not replace running time");

   chk_sec_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_sec |=> sec_shadow_q == $past(pwdata))
      else $error("seconds write lost");

   chk_ns_reserved: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_setup && paddr == ptc_pkg::ADDR_NS) |=> prdata[31:30] == 2'h0)
      else $error("nanoseconds reserved bits not zero");

   chk_frac_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_frac && !snap_cmd) |=> frac_shadow_q == $past(pwdata))
      else $error("fraction write lost");

   chk_step_nominal: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && !load_cmd && !carry && !ns_wrap) |=> ns_live_q == $past(ns_live_q) + 30'h0a)
      else $error("nominal step is not 10 ns");

   chk_step_trimmed: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && !load_cmd && carry && !ns_wrap) |=>
         ns_live_q == $past(ns_live_q) + ($past(eff_dir) ? 30'h0b : 30'h09))
      else $error("trimmed step wrong");

   chk_frac_accum: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && !load_cmd) |=> frac_live_q == $past(frac_live_q) + {2'h0, $past(eff_val)})
      else $error("fraction did not accumulate trim");

   chk_temp_runs: assert property (
      @(posedge pclk) disable iff (!presetn)
      (temp_go && duration_q != 32'h0) |=> temp_active && temp_cnt_q == $past(duration_q))
      else $error("temporary trim did not start");

   chk_temp_count: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && temp_active && !temp_go) |=> temp_cnt_q == $past(temp_cnt_q) - 32'h1)
      else $error("temporary count did not decrement");

   chk_trim_select: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && !load_cmd && !temp_active) |=>
         frac_live_q == $past(frac_live_q) + {2'h0, $past(rate_trim_value_q)})
      else $error("permanent trim not in force");

   chk_temp_select: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && !load_cmd && temp_active) |=>
         frac_live_q == $past(frac_live_q) + {2'h0, $past(temporary_trim_value_q)})
      else $error("temporary trim not in force");

   chk_tick_spacing: assert property (
      @(posedge pclk) disable iff (!presetn)
      tick |=> !tick)
      else $error("reference tick faster than 10 ns");

endmodule // ptc_time_clock

// file: dv/test_ptc_time_clock.sv
// test_ptc_time_clock: self-checking bench for the time counter and its apb registers.
// assumes the design answers apb on pclk and ticks every TICK_DIV cycles.
`timescale 1ns/1ps
module test_ptc_time_clock;
   localparam int unsigned DIV = 2;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, temporary_trim_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, time_seconds_now;
   logic [29:0] time_nanoseconds_now;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int act_ticks = 0;
   int n0;
   logic [31:0] rd, snap_sec, post_sec, s_sec, frac_sh, frac_m, pval, tval, exp_step;
   logic [29:0] snap_ns, post_ns, s_ns, prev_ns;
   logic [30:0] delta;
   logic serr, pdir, tdir, cy, dir, act_prev, resync, mon_on;
   localparam logic [11:0] ADDRS [6] = '{ptc_pkg::ADDR_SEC, ptc_pkg::ADDR_NS,
      ptc_pkg::ADDR_FRAC, ptc_pkg::ADDR_RATE, ptc_pkg::ADDR_TEMP, ptc_pkg::ADDR_DUR};
   localparam logic [31:0] MASKS [6] = '{32'hffffffff, 32'h3fffffff, 32'hffffffff,
      32'hbfffffff, 32'hbfffffff, 32'hffffffff};

   ptc_time_clock #(.TICK_DIV(DIV)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .time_seconds_now(time_seconds_now),
      .time_nanoseconds_now(time_nanoseconds_now),
      .temporary_trim_active(temporary_trim_active));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tally_and_finish;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // one apb transfer; live time is taken at the edge that accepts it
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      serr = pslverr;
      snap_sec = time_seconds_now;
      snap_ns = time_nanoseconds_now;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
      post_sec = time_seconds_now;
      post_ns = time_nanoseconds_now;
      // model follows writes after the edge; trim changes pause checking until next load
      if (wr)
      begin
         if (a == ptc_pkg::ADDR_FRAC)
            frac_sh = d;
         if (a == ptc_pkg::ADDR_RATE || a == ptc_pkg::ADDR_TEMP)
            mon_on = 1'b0;
         if (a == ptc_pkg::ADDR_RATE)
            {pdir, pval} = {d[31], 2'b00, d[29:0]};
         if (a == ptc_pkg::ADDR_TEMP)
            {tdir, tval} = {d[31], 2'b00, d[29:0]};
         if (a == ptc_pkg::ADDR_CMD && d[1])
            resync = 1'b1;
      end
      @(posedge pclk);
   endtask

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask

   // step model: while mon_on is set, each nanosecond change is checked against the fraction carry
   always @(negedge pclk)
   begin
      if (resync)
      begin
         prev_ns = time_nanoseconds_now;
         frac_m = frac_sh;
         resync = 1'b0;
         mon_on = 1'b1;
      end
      else if (mon_on && time_nanoseconds_now !== prev_ns)
      begin
         {cy, frac_m} = {1'b0, frac_m} + {1'b0, (act_prev ? tval : pval)};
         dir = act_prev ? tdir : pdir;
         exp_step = cy ? (dir ? 32'h0000_000b : 32'h0000_0009) : 32'h0000_000a;
         delta = {1'b0, time_nanoseconds_now} - {1'b0, prev_ns};
         if (time_nanoseconds_now < prev_ns)
            delta = delta + {1'b0, ptc_pkg::NS_PER_SEC};
         check({1'b0, delta}, exp_step);
         act_ticks += int'(act_prev);
         prev_ns = time_nanoseconds_now;
      end
      act_prev = temporary_trim_active;
   end

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      {resync, mon_on, act_prev, pdir, tdir} = 5'h00;
      {pval, tval, frac_sh, frac_m} = 128'h0;
      repeat (20) @(posedge pclk);
      check(time_seconds_now, 32'h0000_0000);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++)
         rd_chk(ADDRS[i], 32'h0000_0000);
      rd_chk(ptc_pkg::ADDR_CMD, 32'h0000_0000);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, ADDRS[i], 32'hffff_ffff);
         rd_chk(ADDRS[i], MASKS[i]);
      end
      check({31'h0, serr}, 32'h0000_0000);
      apb(1'b1, 12'h200, 32'hffff_ffff);
      check({31'h0, serr}, 32'h0000_0001);
      rd_chk(12'h200, 32'h0000_0000);
      check({31'h0, serr}, 32'h0000_0001);
      // load just below the seconds rollover, then shadows differ from live time
      apb(1'b1, ptc_pkg::ADDR_SEC, 32'h0000_0007);
      apb(1'b1, ptc_pkg::ADDR_NS, {2'b00, ptc_pkg::NS_PER_SEC - 30'h14});
      apb(1'b1, ptc_pkg::ADDR_FRAC, 32'h1234_5678);
      apb(1'b1, ptc_pkg::ADDR_RATE, 32'h0000_0000);
      apb(1'b1, ptc_pkg::ADDR_TEMP, 32'h0000_0000);
      apb(1'b1, ptc_pkg::ADDR_CMD, 32'h0000_0002);
      check(post_sec, 32'h0000_0007);
      check({2'b00, post_ns}, {2'b00, ptc_pkg::NS_PER_SEC - 30'h14});
      apb(1'b1, ptc_pkg::ADDR_SEC, 32'h0000_0099);
      apb(1'b1, ptc_pkg::ADDR_FRAC, 32'h0000_0000);
      apb(1'b1, ptc_pkg::ADDR_CMD, 32'h0000_0001);
      s_sec = snap_sec;
      s_ns = snap_ns;
      check(s_sec, 32'h0000_0008);
      repeat (2)
      begin
         rd_chk(ptc_pkg::ADDR_SEC, s_sec);
         rd_chk(ptc_pkg::ADDR_NS, {2'b00, s_ns});
         rd_chk(ptc_pkg::ADDR_FRAC, 32'h1234_5678);
         repeat (10) @(posedge pclk);
      end
      // permanent trim one way, temporary trim the other way for 8 ticks
      for (int d = 0; d < 2; d++)
      begin
         apb(1'b1, ptc_pkg::ADDR_RATE, {d[0], 31'h3fff_ffff});
         apb(1'b1, ptc_pkg::ADDR_TEMP, {~d[0], 31'h3fff_ffff});
         apb(1'b1, ptc_pkg::ADDR_DUR, 32'h0000_0008);
         apb(1'b1, ptc_pkg::ADDR_FRAC, 32'h0000_0000);
         apb(1'b1, ptc_pkg::ADDR_CMD, 32'h0000_0002);
         repeat (24) @(posedge pclk);
         n0 = act_ticks;
         apb(1'b1, ptc_pkg::ADDR_CMD, 32'h0000_0004);
         rd_chk(ptc_pkg::ADDR_CMD, 32'h0000_0008);
         repeat (30) @(posedge pclk);
         check(32'(act_ticks - n0), 32'h0000_0008);
         check({31'h0, temporary_trim_active}, 32'h0000_0000);
      end
      apb(1'b1, ptc_pkg::ADDR_DUR, 32'h0000_0000);
      n0 = act_ticks;
      apb(1'b1, ptc_pkg::ADDR_CMD, 32'h0000_0004);
      repeat (10) @(posedge pclk);
      check(32'(act_ticks - n0), 32'h0000_0000);
      tally_and_finish();
   end
endmodule // test_ptc_time_clock
